// File: sim/parameter_write_guard_test.sv
// Purpose: Self-checking bench for pwg_top
// Assumes: Answer one cycle after each request
// Notes:   Reset first, then row table, pin and strap cases, then a second reset
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench
module parameter_write_guard_test;
  logic       core_clk = 0, rstn = 0, lock_pin = 0, oem_code_present = 0;
  wire        req_valid, req_write, req_in_group, ans_valid, fwd_valid, fwd_write;
  wire        param_lock, locked_msg, start_inhibit;
  wire [2:0]  req_source, ans_status;
  wire [3:0]  req_index, fwd_index;
  wire [15:0] req_wdata, ans_rdata, fwd_wdata, service_code;
  int         failures = 0, tests_run = 0;
  typedef struct {logic w; logic [2:0] s; logic g; logic [3:0] i; logic [15:0] d, rd;
    logic [2:0] st;} pwg_row_t;
  pwg_row_t rows[20] = '{
    '{0,2,1,2,16'h0,16'h0,0},
    '{1,2,1,2,16'h04d2,16'h0,2},
    '{1,1,1,2,16'h04d2,16'h0,0},
    '{0,3,1,2,16'h0,16'h04d2,0},
    '{1,1,1,4,16'h1,16'h0,1},
    '{0,4,1,4,16'h0,16'h0,0},
    '{1,1,1,1,16'h270f,16'h0,0},
    '{1,1,1,1,16'h2710,16'h0,3},
    '{0,2,1,1,16'h0,16'h270f,0},
    '{1,1,1,1,16'h04d2,16'h0,0},
    '{1,1,1,5,16'hea5f,16'h0,0},
    '{1,1,1,5,16'hea60,16'h0,3},
    '{0,3,1,5,16'h0,16'hea5f,0},
    '{1,1,1,3,16'h2,16'h0,0},
    '{1,2,1,3,16'h3,16'h0,0},
    '{1,3,1,3,16'h4,16'h0,0},
    '{1,1,1,4,16'h1,16'h0,2},
    '{1,4,1,4,16'h1,16'h0,0},
    '{1,4,0,9,16'h1234,16'h0,5},
    '{0,1,0,7,16'h0,16'h0,5}};
  always #2 core_clk = ~core_clk;
  pwg_top u_dut (.*);
  pwg_master u_mst (.*);
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic req(input logic w, input logic [2:0] s, input logic g, input logic [3:0] i,
      input logic [15:0] d, input logic [2:0] est, input logic [15:0] erd);
    logic [2:0]  st;
    logic [15:0] rd;
    bit          to;
    u_mst.access(w, s, g, i, d, st, rd, to);
    if (to) begin
      failures++;
      finish_test;
    end
    chk("status", {13'h0, est}, {13'h0, st});
    chk("rdata", erd, rd);
    chk("locked_msg", {15'h0, est == 3'h1}, {15'h0, locked_msg});
    chk("fwd_valid", {15'h0, est == 3'h5}, {15'h0, fwd_valid});
    if (est == 3'h5) begin
      chk("fwd_index", {12'h0, i}, {12'h0, fwd_index});
      chk("fwd_write", {15'h0, w}, {15'h0, fwd_write});
      if (w) chk("fwd_wdata", d, fwd_wdata);
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge core_clk) #1;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1 rstn = 1;
    chk("lock", 0, param_lock);
    chk("inhibit", 0, start_inhibit);
    chk("service", 0, service_code);
    $display("test reset done");
    foreach (rows[k]) req(rows[k].w, rows[k].s, rows[k].g, rows[k].i, rows[k].d,
      rows[k].st, rows[k].rd);
    settle;
    chk("lock", 0, param_lock);
    chk("inhibit", 1, start_inhibit);
    chk("service", 16'hea5f, service_code);
    $display("test rows done");
    lock_pin = 1;
    settle;
    chk("lock", 1, param_lock);
    req(1, 4, 1, 4, 16'h0, 1, 16'h0);
    req(0, 3, 1, 4, 16'h0, 0, 16'h1);
    lock_pin = 0;
    settle;
    chk("lock", 0, param_lock);
    $display("test lock pin done");
    oem_code_present = 1;
    settle;
    req(0, 2, 1, 2, 16'h0, 4, 16'h0);
    req(0, 2, 1, 1, 16'h0, 0, 16'h04d2);
    $display("test strap done");
    rstn = 0;
    repeat (3) @(posedge core_clk) #1;
    rstn = 1;
    chk("inhibit", 0, start_inhibit);
    chk("service", 0, service_code);
    $display("test second reset done");
    finish_test;
  end
endmodule // parameter_write_guard_test
`default_nettype wire

// File: sim/pwg_master.sv
// Purpose: Keypad or fieldbus master issuing parameter requests
// Assumes: Caller enters just after a rising edge
// Notes:   One request at a time, one idle cycle between them
`include "pwg_consts.vh"
`timescale 1ns/100ps
`default_nettype none
// ==========
// Master model
module pwg_master (
  input wire logic                   core_clk, ans_valid,
  input wire logic [`PWG_ST_W-1:0]   ans_status,
  input wire logic [`PWG_DATA_W-1:0] ans_rdata,
  output logic                       req_valid, req_write, req_in_group,
  output logic [`PWG_SRC_W-1:0]      req_source,
  output logic [`PWG_IDX_W-1:0]      req_index,
  output logic [`PWG_DATA_W-1:0]     req_wdata
);
  initial begin
    {req_valid, req_write, req_in_group, req_source, req_index, req_wdata} = '0;
  end
  task automatic access(input logic w, input logic [2:0] s, input logic g,
      input logic [3:0] i, input logic [15:0] d,
      output logic [2:0] st, output logic [15:0] rd, output bit to);
    int n;
    @(posedge core_clk) #1;
    req_valid = 1'b1;
    req_write = w;
    req_source = s;
    req_in_group = g;
    req_index = i;
    req_wdata = d;
    @(posedge core_clk) #1;
    // Index and write data inverted so a late sample cannot pass
    req_valid = 1'b0;
    req_index = ~i;
    req_wdata = ~d;
    for (n = 0; n < 4 && ans_valid !== 1'b1; n++) @(posedge core_clk) #1;
    st = ans_status;
    rd = ans_rdata;
    to = (ans_valid !== 1'b1);
  endtask
endmodule // pwg_master
`default_nettype wire

// File: sim/pwg_monitor.sv
// Purpose: Port checker for the parameter write guard
// Assumes: Sees only the ports of pwg_top
// Notes:   Bound to every pwg_top instance
`include "pwg_consts.vh"
`timescale 1ns/100ps
`default_nettype none
// ==========
// Checker
module pwg_monitor (
  // Clock, reset and pins
  input wire logic                   core_clk, rstn, lock_pin, oem_code_present,
  // Request, with forwarded index and data
  input wire logic                   req_valid, req_write, req_in_group,
  input wire logic [`PWG_SRC_W-1:0]  req_source,
  input wire logic [`PWG_IDX_W-1:0]  req_index, fwd_index,
  input wire logic [`PWG_DATA_W-1:0] req_wdata, fwd_wdata,
  // Answer, forwarding and drive side
  input wire logic                   ans_valid, fwd_valid, fwd_write,
  input wire logic                   param_lock, locked_msg, start_inhibit,
  input wire logic [`PWG_ST_W-1:0]   ans_status,
  input wire logic [`PWG_DATA_W-1:0] ans_rdata, service_code
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire rd_ref = req_valid && !req_write && req_in_group && req_index == `PWG_IDX_CODE_REF;
  a_answer_each_req: assert property (req_valid |=> ans_valid)
    else $error("request without answer");
  a_no_stray_ans: assert property (!req_valid |=> !ans_valid && !fwd_valid)
    else $error("answer without request");
  a_read_served: assert property (req_valid && !req_write && !rd_ref |=>
    ans_status != `PWG_ST_LOCKED && ans_status != `PWG_ST_WRONG_SRC) else $error("read refused");
  a_locked_msg_status: assert property (locked_msg == (ans_valid && ans_status == `PWG_ST_LOCKED))
    else $error("locked message mismatch");
  a_locked_cause: assert property (locked_msg |-> $past(param_lock) && $past(req_write))
    else $error("locked refusal without lock");
  a_lock_pin_engage: assert property (lock_pin [*4] |=> param_lock)
    else $error("lock pin ignored");
  a_oem_read_block: assert property (oem_code_present [*3] ##1 rd_ref && oem_code_present |=>
    ans_status == `PWG_ST_READ_BLOCKED && ans_rdata == 16'h0000) else $error("code read not blocked");
  a_inhibit_cause: assert property ($changed(start_inhibit) |->
    $past(ans_valid) && $past(ans_status) == `PWG_ST_OK) else $error("inhibit changed alone");
  a_service_cause: assert property ($changed(service_code) |-> ans_valid &&
    ans_status == `PWG_ST_OK && service_code <= `PWG_SERVICE_MAX) else $error("service code bad");
  c_locked: cover property (locked_msg);
  c_blocked: cover property (ans_valid && ans_status == `PWG_ST_READ_BLOCKED);
  c_forward: cover property (fwd_valid);
endmodule // pwg_monitor
bind pwg_top pwg_monitor u_mon (.*);
`default_nettype wire

// File: verilog/pwg_consts.vh
// Purpose: Constants of the parameter write guard
// Assumes: Included by bare name from the design files
// Notes:   Indices follow the security parameter group numbering
`ifndef PWG_CONSTS_VH
`define PWG_CONSTS_VH

// ==========================================================================
// Parameter indices inside the security group
`define PWG_IDX_W            4
`define PWG_IDX_CODE_ENTRY   4'h1
`define PWG_IDX_CODE_REF     4'h2
`define PWG_IDX_SRC_SEL      4'h3
`define PWG_IDX_INHIBIT      4'h4
`define PWG_IDX_SERVICE      4'h5

// ==========================================================================
// Widths and value limits
`define PWG_DATA_W           16
`define PWG_CODE_W           14
`define PWG_CODE_MAX         14'h270f
`define PWG_SERVICE_MAX      16'hea5f
`define PWG_SRC_W            3

// ==========================================================================
// Parametrising sources
`define PWG_SRC_KEYPAD       3'h1
`define PWG_SRC_MODBUS       3'h2
`define PWG_SRC_CANOPEN      3'h3
`define PWG_SRC_PROFIBUS     3'h4

// ==========================================================================
// Reset values
`define PWG_RST_CODE         14'h0000
`define PWG_RST_SRC          3'h1
`define PWG_RST_INHIBIT      1'h0
`define PWG_RST_SERVICE      16'h0000

// ==========================================================================
// Answer status codes
`define PWG_ST_W             3
`define PWG_ST_OK            3'h0
`define PWG_ST_LOCKED        3'h1
`define PWG_ST_WRONG_SRC     3'h2
`define PWG_ST_RANGE         3'h3
`define PWG_ST_READ_BLOCKED  3'h4
`define PWG_ST_FORWARDED     3'h5

`endif

// File: verilog/pwg_sync2.v
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Inputs are slow levels from pins
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none

module pwg_sync2 #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rstn,
  // Asynchronous levels in
  input  wire [WIDTH-1:0] async_in,
  // Synchronised levels out
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  // ========================================================================
  // Per-bit chain
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge core_clk) begin
        if (!rstn) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;

endmodule // pwg_sync2

`default_nettype wire

// File: verilog/pwg_top.v
// Purpose: Guards parameter writes by code lock, lock pin and source select
// Assumes: One parameter request per cycle from the access arbiter
// Notes:   Answer comes one cycle after the request is taken
`include "pwg_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module pwg_top (
  // Clock and reset
  input  wire                    core_clk,
  input  wire                    rstn,
  // Pins
  input  wire                    lock_pin,
  input  wire                    oem_code_present,
  // Parameter request
  input  wire                    req_valid,
  input  wire                    req_write,
  input  wire [`PWG_SRC_W-1:0]   req_source,
  input  wire                    req_in_group,
  input  wire [`PWG_IDX_W-1:0]   req_index,
  input  wire [`PWG_DATA_W-1:0]  req_wdata,
  // Parameter answer
  output reg                     ans_valid,
  output reg  [`PWG_ST_W-1:0]    ans_status,
  output reg  [`PWG_DATA_W-1:0]  ans_rdata,
  // Forwarded accesses to other parameter groups
  output reg                     fwd_valid,
  output reg                     fwd_write,
  output reg  [`PWG_IDX_W-1:0]   fwd_index,
  output reg  [`PWG_DATA_W-1:0]  fwd_wdata,
  // Drive side state
  output reg                     param_lock,
  output reg                     locked_msg,
  output reg                     start_inhibit,
  output reg  [`PWG_DATA_W-1:0]  service_code
);

  // ========================================================================
  // Stored parameters
  reg  [`PWG_CODE_W-1:0] lock_code_entry;
  reg  [`PWG_CODE_W-1:0] lock_code_reference;
  reg  [`PWG_SRC_W-1:0]  write_source_select;
  reg                    start_pulse_inhibit;

  // ========================================================================
  // Pin synchronisation
  wire [1:0] pins_sync;
  wire       lock_pin_s;
  wire       oem_s;

  pwg_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({oem_code_present, lock_pin}),
    .sync_out (pins_sync)
  );

  assign lock_pin_s = pins_sync[0];
  assign oem_s      = pins_sync[1];

  // ========================================================================
  // Decode helpers
  function idx_known;
    input [`PWG_IDX_W-1:0] idx;
    begin
      idx_known = (idx == `PWG_IDX_CODE_ENTRY) || (idx == `PWG_IDX_CODE_REF) ||
                  (idx == `PWG_IDX_SRC_SEL)    || (idx == `PWG_IDX_INHIBIT)  ||
                  (idx == `PWG_IDX_SERVICE);
    end
  endfunction

  function code_ok;
    input [`PWG_DATA_W-1:0] val;
    begin
      code_ok = (val <= {2'b00, `PWG_CODE_MAX});
    end
  endfunction

  function src_ok;
    input [`PWG_SRC_W-1:0] src;
    begin
      src_ok = (src >= `PWG_SRC_KEYPAD) && (src <= `PWG_SRC_PROFIBUS);
    end
  endfunction

  // ========================================================================
  // Lock state from current contents
  wire lock_now;
  assign lock_now = (lock_code_entry != lock_code_reference)
                  | lock_pin_s;

  // ========================================================================
  // Write decision
  wire                   is_wr;
  wire                   is_rd;
  wire                   grp_req;
  wire                   src_match;
  wire                   entry_target;
  reg                    range_ok;
  reg  [`PWG_ST_W-1:0]   next_wr_status;
  wire                   wr_accept;

  assign is_wr        = req_valid & req_write;
  assign is_rd        = req_valid & ~req_write;
  assign grp_req      = req_in_group & idx_known(req_index);
  assign src_match    = (req_source == write_source_select);
  // Code entry stays writable while locked, else a lock could never be lifted
  assign entry_target = req_in_group && (req_index == `PWG_IDX_CODE_ENTRY);

  always @* begin
    range_ok = 1'b1;
    if (req_in_group) begin
      case (req_index)
        `PWG_IDX_CODE_ENTRY: range_ok = code_ok(req_wdata);
        `PWG_IDX_CODE_REF:   range_ok = code_ok(req_wdata);
        `PWG_IDX_SRC_SEL:    range_ok = src_ok(req_wdata[`PWG_SRC_W-1:0]) &&
                                        (req_wdata[`PWG_DATA_W-1:`PWG_SRC_W] == 13'h0000);
        `PWG_IDX_INHIBIT:    range_ok = (req_wdata[`PWG_DATA_W-1:1] == 15'h0000);
        `PWG_IDX_SERVICE:    range_ok = (req_wdata <= `PWG_SERVICE_MAX);
        default:             range_ok = 1'b0;
      endcase
    end
  end

  always @* begin
    if (!src_match) begin
      next_wr_status = `PWG_ST_WRONG_SRC;
    end else if (lock_now && !entry_target) begin
      next_wr_status = `PWG_ST_LOCKED;
    end else if (!range_ok) begin
      next_wr_status = `PWG_ST_RANGE;
    end else if (!grp_req) begin
      next_wr_status = req_in_group ? `PWG_ST_RANGE : `PWG_ST_FORWARDED;
    end else begin
      next_wr_status = `PWG_ST_OK;
    end
  end

  // Only a clean decision touches storage
  assign wr_accept = is_wr && (next_wr_status == `PWG_ST_OK);

  // ========================================================================
  // Read decision and data
  reg [`PWG_ST_W-1:0]   next_rd_status;
  reg [`PWG_DATA_W-1:0] next_rd_data;

  always @* begin
    next_rd_status = `PWG_ST_OK;
    next_rd_data   = 16'h0000;
    if (!req_in_group) begin
      next_rd_status = `PWG_ST_FORWARDED;
    end else begin
      case (req_index)
        `PWG_IDX_CODE_ENTRY: next_rd_data = {2'b00, lock_code_entry};
        `PWG_IDX_CODE_REF: begin
          if (oem_s) begin
            next_rd_status = `PWG_ST_READ_BLOCKED;
          end else begin
            next_rd_data   = {2'b00, lock_code_reference};
          end
        end
        `PWG_IDX_SRC_SEL:    next_rd_data = {13'h0000, write_source_select};
        `PWG_IDX_INHIBIT:    next_rd_data = {15'h0000, start_pulse_inhibit};
        `PWG_IDX_SERVICE:    next_rd_data = service_code;
        default:             next_rd_status = `PWG_ST_RANGE;
      endcase
    end
  end

  // ========================================================================
  // Parameter storage
  always @(posedge core_clk) begin
    if (!rstn) begin
      lock_code_entry     <= `PWG_RST_CODE;
      lock_code_reference <= `PWG_RST_CODE;
      write_source_select <= `PWG_RST_SRC;
      start_pulse_inhibit <= `PWG_RST_INHIBIT;
      service_code        <= `PWG_RST_SERVICE;
    end else if (wr_accept) begin
      case (req_index)
        `PWG_IDX_CODE_ENTRY: lock_code_entry     <= req_wdata[`PWG_CODE_W-1:0];
        `PWG_IDX_CODE_REF:   lock_code_reference <= req_wdata[`PWG_CODE_W-1:0];
        `PWG_IDX_SRC_SEL:    write_source_select <= req_wdata[`PWG_SRC_W-1:0];
        `PWG_IDX_INHIBIT:    start_pulse_inhibit <= req_wdata[0];
        `PWG_IDX_SERVICE:    service_code        <= req_wdata;
        default:             service_code        <= service_code;
      endcase
    end
  end

  // ========================================================================
  // Answer port
  always @(posedge core_clk) begin
    if (!rstn) begin
      ans_valid  <= 1'b0;
      ans_status <= `PWG_ST_OK;
      ans_rdata  <= 16'h0000;
    end else begin
      ans_valid <= req_valid;
      if (is_wr) begin
        ans_status <= next_wr_status;
        ans_rdata  <= 16'h0000;
      end else if (is_rd) begin
        ans_status <= next_rd_status;
        ans_rdata  <= next_rd_data;
      end else begin
        ans_status <= `PWG_ST_OK;
        ans_rdata  <= 16'h0000;
      end
    end
  end

  // ========================================================================
  // Forwarding of other groups
  // Foreign writes pass only under the same source and lock checks
  always @(posedge core_clk) begin
    if (!rstn) begin
      fwd_valid <= 1'b0;
    end else begin
      fwd_valid <= (is_rd && !req_in_group) ||
                   (is_wr && next_wr_status == `PWG_ST_FORWARDED);
    end
  end

  // Payload copied every cycle; only meaningful while fwd_valid stands
  always @(posedge core_clk) begin
    if (!rstn) begin
      fwd_write <= 1'b0;
      fwd_index <= 4'h0;
      fwd_wdata <= 16'h0000;
    end else begin
      fwd_write <= is_wr;
      fwd_index <= req_index;
      fwd_wdata <= req_wdata;
    end
  end

  // ========================================================================
  // Drive side state
  // Lock level is registered so the panel never sees a decode glitch
  always @(posedge core_clk) begin
    if (!rstn) begin
      param_lock <= 1'b0;
    end else begin
      param_lock <= lock_now;
    end
  end

  // One pulse per write refused for lock; the panel raises its locked message from it
  always @(posedge core_clk) begin
    if (!rstn) begin
      locked_msg <= 1'b0;
    end else begin
      locked_msg <= is_wr && (next_wr_status == `PWG_ST_LOCKED);
    end
  end

  // Follows the stored setting a cycle late; start logic must wait one cycle
  always @(posedge core_clk) begin
    if (!rstn) begin
      start_inhibit <= 1'b0;
    end else begin
      start_inhibit <= start_pulse_inhibit;
    end
  end

endmodule // pwg_top

`default_nettype wire
